// ### src/deiu_top.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
module deiu_top
  import deiu_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sync_fault_event,
  input wire logic checksum_fault_event,
  input wire logic uncorrectable_header_fault_event,
  input wire logic corrected_header_fault_event,
  input wire logic sot_sync_fault_event,
  input wire logic eot_sync_fault_event,
  input wire logic escape_entry_fault_event,
  input wire logic lp_sync_fault_event,
  input wire logic false_control_fault_event,
  input wire logic lane_merge_fault_event,
  input wire logic leader_fault_event,
  input wire logic pll_locked,
  output logic irq_out,
  output logic irq_oe
);
  logic irq_output_enable;
  logic [7:0] irq_flag_enable;
  logic [7:0] error_status;
  logic [7:0] next_status;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [11:0] ev_sync;
  logic pll_lock_d;
  logic pll_lock_seen;
  logic pll_lost;
  logic any_pending;

  // event pins come from the packet processor and pll: two flops each
  deiu_sync2 #(
    .WIDTH(12)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din({pll_locked, leader_fault_event, lane_merge_fault_event,
          false_control_fault_event, lp_sync_fault_event,
          escape_entry_fault_event, eot_sync_fault_event,
          sot_sync_fault_event, corrected_header_fault_event,
          uncorrectable_header_fault_event, checksum_fault_event,
          sync_fault_event}),
    .dout(ev_sync)
  );

  // lock-to-unlock edge detect; no edge before lock was first seen
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pll_lock_d <= 1'b0;
      pll_lock_seen <= 1'b0;
    end
    else
    begin
      pll_lock_d <= ev_sync[11];
      if (ev_sync[11])
        pll_lock_seen <= 1'b1;
    end
  end

  assign pll_lost = pll_lock_seen & pll_lock_d & ~ev_sync[11];

  always_comb
  begin
    set_vec = DEIU_ZERO;
    set_vec[DEIU_BIT_SYNC] = ev_sync[0];
    set_vec[DEIU_BIT_CHECKSUM] = ev_sync[1];
    set_vec[DEIU_BIT_UNC_HDR] = ev_sync[2];
    set_vec[DEIU_BIT_COR_HDR] = ev_sync[3];
    set_vec[DEIU_BIT_PROTOCOL] = |ev_sync[9:4];
    set_vec[DEIU_BIT_LEADER] = ev_sync[10];
    set_vec[DEIU_BIT_PLL] = pll_lost;
  end

  // write-one-to-clear; zero bits leave the flag alone
  always_comb
  begin
    clr_vec = DEIU_ZERO;
    if (reg_wr && reg_addr == DEIU_OFS_STATUS)
      clr_vec = reg_wdata & DEIU_FLAG_MASK;
  end

  // a new event in the clearing cycle wins
  assign next_status = ((error_status & ~clr_vec) | set_vec)
                       & DEIU_FLAG_MASK;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      error_status <= DEIU_STATUS_RST;
    else
      error_status <= next_status;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      irq_output_enable <= DEIU_OUT_CTRL_RST[DEIU_BIT_OUT_EN];
    else if (reg_wr && reg_addr == DEIU_OFS_OUT_CTRL)
      irq_output_enable <= reg_wdata[DEIU_BIT_OUT_EN];
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      irq_flag_enable <= DEIU_FLAG_EN_RST;
    else if (reg_wr && reg_addr == DEIU_OFS_FLAG_EN)
      irq_flag_enable <= reg_wdata & DEIU_FLAG_MASK;
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= DEIU_ZERO;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        DEIU_OFS_OUT_CTRL:
          reg_rdata <= {7'h00, irq_output_enable};
        DEIU_OFS_FLAG_EN:
          reg_rdata <= irq_flag_enable;
        DEIU_OFS_STATUS:
          reg_rdata <= error_status;
        default:
          reg_rdata <= DEIU_ZERO;
      endcase
    end
    else
      reg_rdata <= DEIU_ZERO;
  end

  assign any_pending = |(next_status & irq_flag_enable);

  // pin: oe follows the global enable; level follows enabled flags
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_oe <= 1'b0;
      irq_out <= 1'b0;
    end
    else
    begin
      irq_oe <= irq_output_enable;
      irq_out <= irq_output_enable & any_pending;
    end
  end

  sync_to_status_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(ev_sync[0]) |=> error_status[DEIU_BIT_SYNC])
    else $error("sync fault did not set flag");

  checksum_set_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    ev_sync[1] |=> error_status[DEIU_BIT_CHECKSUM])
    else $error("checksum fault did not set flag");

  header_unc_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    ev_sync[2] |=> error_status[DEIU_BIT_UNC_HDR])
    else $error("uncorrectable header fault did not set flag");

  header_cor_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    ev_sync[3] |=> error_status[DEIU_BIT_COR_HDR])
    else $error("corrected header fault did not set flag");

  leader_set_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    ev_sync[10] |=> error_status[DEIU_BIT_LEADER])
    else $error("leader fault did not set flag");

  protocol_any_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (|ev_sync[9:4]) |=> error_status[DEIU_BIT_PROTOCOL])
    else $error("protocol fault did not set flag");

  pll_lost_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    pll_lost |=> error_status[DEIU_BIT_PLL])
    else $error("pll unlock did not set flag");

  sequence wr_clear_s;
    reg_wr && reg_addr == DEIU_OFS_STATUS && set_vec == DEIU_ZERO;
  endsequence

  clear_one_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    wr_clear_s |=> ((error_status & $past(reg_wdata)) == DEIU_ZERO)
      && ((error_status | $past(reg_wdata)) ==
          ($past(error_status) | $past(reg_wdata)))
    ) else $error("status clear wrong");

  oe_follows_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    !irq_output_enable |=> !irq_oe && !irq_out)
    else $error("irq pin driven while disabled");

  irq_level_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    ##1 irq_out == $past(irq_output_enable &&
                         |(next_status & irq_flag_enable)))
    else $error("irq level mismatch");

  reserved_zero_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    !error_status[1] && !irq_flag_enable[1])
    else $error("reserved bit set");

  sequence wr_out_ctrl_s;
    reg_wr && reg_addr == DEIU_OFS_OUT_CTRL;
  endsequence

  out_ctrl_write_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    wr_out_ctrl_s |=>
      irq_output_enable == $past(reg_wdata[DEIU_BIT_OUT_EN]))
    else $error("output enable write lost");

  sequence wr_flag_en_s;
    reg_wr && reg_addr == DEIU_OFS_FLAG_EN;
  endsequence

  flag_en_write_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    wr_flag_en_s |=>
      irq_flag_enable == ($past(reg_wdata) & DEIU_FLAG_MASK))
    else $error("flag enable write lost");

  sequence rd_status_s;
    reg_rd && reg_addr == DEIU_OFS_STATUS;
  endsequence

  rd_status_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rd_status_s |=>
      reg_rdata == $past(error_status))
    else $error("status read wrong");

  sequence rd_flag_en_s;
    reg_rd && reg_addr == DEIU_OFS_FLAG_EN;
  endsequence

  rd_flag_en_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    rd_flag_en_s |=>
      reg_rdata == $past(irq_flag_enable))
    else $error("flag enable read wrong");

  rd_out_ctrl_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (reg_rd && reg_addr == DEIU_OFS_OUT_CTRL) |=>
      reg_rdata == {7'h00, $past(irq_output_enable)})
    else $error("output control read wrong");

  rd_unmapped_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (reg_rd && reg_addr != DEIU_OFS_OUT_CTRL &&
     reg_addr != DEIU_OFS_FLAG_EN && reg_addr != DEIU_OFS_STATUS) |=>
      reg_rdata == DEIU_ZERO)
    else $error("unmapped read not zero");

  rd_idle_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == DEIU_ZERO)
    else $error("read data outside read slot");

  status_hold_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (!(reg_wr && reg_addr == DEIU_OFS_STATUS) && set_vec == DEIU_ZERO)
      |=> $stable(error_status))
    else $error("status changed without cause");

  pll_quiet_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (!pll_lost && !error_status[DEIU_BIT_PLL]) |=>
      !error_status[DEIU_BIT_PLL])
    else $error("pll flag set without unlock");

  oe_track_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    ##1 irq_oe == $past(irq_output_enable))
    else $error("irq enable pin lags wrong");
endmodule

// ### src/deiu_pkg.sv
package deiu_pkg;
  // register offsets
  localparam logic [7:0] DEIU_OFS_OUT_CTRL = 8'hE0;
  localparam logic [7:0] DEIU_OFS_FLAG_EN = 8'hE1;
  localparam logic [7:0] DEIU_OFS_STATUS = 8'hE5;
  // field positions
  localparam int DEIU_BIT_OUT_EN = 0;
  localparam int DEIU_BIT_SYNC = 7;
  localparam int DEIU_BIT_CHECKSUM = 6;
  localparam int DEIU_BIT_UNC_HDR = 5;
  localparam int DEIU_BIT_COR_HDR = 4;
  localparam int DEIU_BIT_PROTOCOL = 3;
  localparam int DEIU_BIT_LEADER = 2;
  localparam int DEIU_BIT_PLL = 0;
  // writable / implemented bits
  localparam logic [7:0] DEIU_OUT_CTRL_MASK = 8'h01;
  localparam logic [7:0] DEIU_FLAG_MASK = 8'hFD;
  // reset values
  localparam logic [7:0] DEIU_OUT_CTRL_RST = 8'h00;
  localparam logic [7:0] DEIU_FLAG_EN_RST = 8'h00;
  localparam logic [7:0] DEIU_STATUS_RST = 8'h01;
  localparam logic [7:0] DEIU_ZERO = 8'h00;
endpackage

// ### src/deiu_sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for level inputs, one per bit
module deiu_sync2
  import deiu_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          stage1[gi] <= 1'b0;
          dout[gi] <= 1'b0;
        end
        else
        begin
          stage1[gi] <= din[gi];
          dout[gi] <= stage1[gi];
        end
      end
    end
  endgenerate
endmodule

// ### dv/deiu_far_model.sv
`timescale 1ns/1ps
// packet processor and pll monitor seen from the error block
module deiu_far_model
(
  input wire logic mclk,
  input wire logic [3:0] sel,
  input wire logic fire,
  input wire logic lock_req,
  output logic [10:0] ev = 11'h000,
  output logic pll_locked = 1'h0
);
  // one-cycle pulse on the chosen source; sources 4 to 9 share bit 3
  always @(posedge mclk)
  begin
    ev <= fire ? (11'h001 << sel) : 11'h000;
    pll_locked <= lock_req;
  end
endmodule

// ### dv/dsi_error_irq_unit_tb.sv
`timescale 1ns/1ps
module dsi_error_irq_unit_tb;
  import deiu_pkg::*;
  logic mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rd_q = 0;
  logic fire = 0, lock_req = 0, pll_locked, irq_out, irq_oe;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
  logic [3:0] sel = 4'h0;
  logic [10:0] ev;
  logic [7:0] exp_q[$];
  int mismatches = 0, tests_run = 0, seed = 85590;
  always #2.5 mclk = ~mclk;
  deiu_far_model far (.mclk(mclk), .sel(sel), .fire(fire),
    .lock_req(lock_req), .ev(ev), .pll_locked(pll_locked));
  deiu_top dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sync_fault_event(ev[0]),
    .checksum_fault_event(ev[1]),
    .uncorrectable_header_fault_event(ev[2]),
    .corrected_header_fault_event(ev[3]), .sot_sync_fault_event(ev[4]),
    .eot_sync_fault_event(ev[5]), .escape_entry_fault_event(ev[6]),
    .lp_sync_fault_event(ev[7]), .false_control_fault_event(ev[8]),
    .lane_merge_fault_event(ev[9]), .leader_fault_event(ev[10]),
    .pll_locked(pll_locked), .irq_out(irq_out), .irq_oe(irq_oe));
  task automatic chk(input string nm, input logic [7:0] e, s);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'h0;
  endtask
  task automatic pulse(input logic [3:0] s);
    @(posedge mclk);
    sel <= s;
    fire <= 1'h1;
    @(posedge mclk);
    fire <= 1'h0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic pin(input logic oe, out);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("irq_oe", {7'h00, oe}, {7'h00, irq_oe});
    if (oe)
      chk("irq_out", {7'h00, out}, {7'h00, irq_out});
  endtask
  function automatic logic [7:0] ebit(input int i);
    return i == 0 ? 8'h80 : i == 1 ? 8'h40 : i == 2 ? 8'h20 :
      i == 3 ? 8'h10 : i < 10 ? 8'h08 : 8'h04;
  endfunction
  // read data stand only in the cycle after the read strobe
  always @(posedge mclk) rd_q <= reg_rd;
  always @(negedge mclk)
    if (rd_q)
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);
  initial
  begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    nrst <= 1'h1;
    pin(1'h0, 1'h0);
    rd(DEIU_OFS_OUT_CTRL, DEIU_OUT_CTRL_RST);
    rd(DEIU_OFS_FLAG_EN, DEIU_FLAG_EN_RST);
    rd(DEIU_OFS_STATUS, 8'h01);
    wr(DEIU_OFS_STATUS, 8'h00);
    rd(DEIU_OFS_STATUS, 8'h01);
    wr(DEIU_OFS_STATUS, 8'h01);
    rd(DEIU_OFS_STATUS, 8'h00);
    wr(8'hE2, 8'hFF);
    rd(8'hE2, 8'h00);
    wr(DEIU_OFS_OUT_CTRL, 8'hFF);
    rd(DEIU_OFS_OUT_CTRL, 8'h01);
    for (int i = 0; i < 11; i++)
    begin
      pulse(i[3:0]);
      rd(DEIU_OFS_STATUS, ebit(i));
      wr(DEIU_OFS_STATUS, ~ebit(i));
      rd(DEIU_OFS_STATUS, ebit(i));
      wr(DEIU_OFS_STATUS, ebit(i));
      rd(DEIU_OFS_STATUS, 8'h00);
    end
    pulse(4'h0);
    pin(1'h1, 1'h0);
    wr(DEIU_OFS_FLAG_EN, 8'h80);
    pin(1'h1, 1'h1);
    wr(DEIU_OFS_FLAG_EN, 8'h7F);
    pin(1'h1, 1'h0);
    wr(DEIU_OFS_FLAG_EN, 8'hFF);
    pin(1'h1, 1'h1);
    wr(DEIU_OFS_STATUS, 8'hFF);
    pin(1'h1, 1'h0);
    wr(DEIU_OFS_OUT_CTRL, 8'h00);
    pin(1'h0, 1'h0);
    lock_req <= 1'h1;
    repeat (8) @(posedge mclk);
    lock_req <= 1'h0;
    repeat (8) @(posedge mclk);
    rd(DEIU_OFS_STATUS, 8'h01);
    repeat (8)
    begin
      rv = 8'($random(seed));
      wr(DEIU_OFS_FLAG_EN, rv);
      rd(DEIU_OFS_FLAG_EN, rv & DEIU_FLAG_MASK);
    end
    repeat (3) @(posedge mclk);
    give_verdict();
  end
endmodule
